// [src/coil_current_ctrl_regs.sv]
// control and status registers of the voice coil current driver
// assumes a byte register port fed by the two-wire serial slave on the core clock,
// and analog detector levels that arrive asynchronously.
// What this block does
// - soft reset restores defaults, enters standby
// - soft reset bit itself is not cleared
// - setpoint code split over 0x03 and 0x04
// - zero code disables output, enters standby
// - code maps linearly to coil current
// - setpoint applied only after paired multibyte write
// - diagnostic request starts check, results after 1ms
// - short flag reports detector short result
// - open flag reports detector open result
// - short and open flags zero while diagnostic request low
// - overtemperature flag stops and resumes operation
// - overcurrent sets lock flag, outputs high impedance
// - auto-retry tries every 100ms, clears lock
// - without retry, lock holds until standby
// - retry enable is bit 7 of 0x06
// - registers addressed by byte, multibyte transfers
`timescale 1ns/1ps
module coil_current_ctrl_regs #(
    parameter int DIAGNOSTIC_REQUEST_CYCLES = coil_regs_pkg::DIAGNOSTIC_REQUEST_DELAY_CYCLES,
    parameter int RETRY_CYCLES = coil_regs_pkg::RETRY_PERIOD_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_wr_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_xfer_end,
    input wire logic [7:0] i_rd_addr,
    output logic [7:0] o_rd_data,
    input wire logic i_det_short,
    input wire logic i_det_open,
    input wire logic i_det_overtemp_hi,
    input wire logic i_det_overtemp_lo,
    input wire logic i_det_overcurrent,
    output logic [9:0] o_active_code,
    output logic o_drive_enable,
    output logic o_coil_drive_positive_oe,
    output logic o_coil_drive_negative_oe,
    output logic o_standby,
    output logic o_diagnostic_request_active,
    output logic o_shaper_enable,
    output logic [5:0] o_options
);
    typedef enum logic [1:0] {
        ST_STANDBY = 2'b00,
        ST_RUN = 2'b01,
        ST_LOCKED = 2'b11,
        ST_RETRY = 2'b10
    } drive_state_t;

    drive_state_t state;
    drive_state_t next_state;

    // two-flop synchronisers for detector levels
    logic [4:0] det_meta;
    logic [4:0] det_sync;
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            det_meta <= 5'h00;
            det_sync <= 5'h00;
        end else begin
            det_meta <= {i_det_overcurrent, i_det_overtemp_lo, i_det_overtemp_hi,
                         i_det_open, i_det_short};
            det_sync <= det_meta;
        end
    end
    wire logic short_s = det_sync[0];
    wire logic open_s = det_sync[1];
    wire logic hot_s = det_sync[2];
    wire logic cool_s = det_sync[3];
    wire logic overcur_s = det_sync[4];

    logic soft_reset_bit;
    logic shaper_en;
    logic [1:0] coil_current_upper;
    logic [7:0] coil_current_lower;
    logic [1:0] upper_shadow;
    logic pair_pending;
    logic diagnostic_request;
    logic diagnostic_request_valid;
    logic overtemp_flag;
    logic overcurrent_lock_flag;
    logic [7:0] operating_options;
    logic upper_armed;

    // byte write decode
    wire logic wr_sys = i_wr_en && (i_addr == coil_regs_pkg::ADDR_SYSTEM_CONTROL);
    wire logic wr_upper = i_wr_en && (i_addr == coil_regs_pkg::ADDR_CURRENT_UPPER);
    wire logic wr_lower = i_wr_en && (i_addr == coil_regs_pkg::ADDR_CURRENT_LOWER);
    wire logic wr_flags = i_wr_en && (i_addr == coil_regs_pkg::ADDR_FLAGS);
    wire logic wr_opts = i_wr_en && (i_addr == coil_regs_pkg::ADDR_OPTIONS);
    wire logic soft_reset_request = wr_sys && i_wr_data[coil_regs_pkg::BIT_SOFT_RESET];

    // commit when the transfer that wrote upper then lower ends
    wire logic commit = i_xfer_end && pair_pending;
    wire logic [9:0] next_code = {upper_shadow, coil_current_lower};
    // standby follows the committed code, not the register bytes
    wire logic zero_code = (o_active_code == coil_regs_pkg::CODE_STANDBY);
    wire logic retry_en = operating_options[coil_regs_pkg::BIT_RETRY];

    coil_timer_if diagnostic_request_tmr();
    coil_timer_if retry_tmr();

    coil_interval_timer #(.CYCLES(DIAGNOSTIC_REQUEST_CYCLES)) u_diagnostic_request_timer (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .tmr(diagnostic_request_tmr)
    );
    coil_interval_timer #(.CYCLES(RETRY_CYCLES)) u_retry_timer (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .tmr(retry_tmr)
    );

    wire logic diagnostic_request_rise = wr_flags && i_wr_data[coil_regs_pkg::BIT_DIAGNOSTIC_REQUEST]
        && !diagnostic_request;
    assign diagnostic_request_tmr.start = diagnostic_request_rise;
    assign diagnostic_request_tmr.run = diagnostic_request && !diagnostic_request_valid;
    assign retry_tmr.start = (state != ST_LOCKED) && (next_state == ST_LOCKED);
    assign retry_tmr.run = (state == ST_LOCKED) && retry_en;

    // bus-visible registers; soft reset keeps its own bit
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            soft_reset_bit <= 1'b0;
        end else if (wr_sys) begin
            soft_reset_bit <= i_wr_data[coil_regs_pkg::BIT_SOFT_RESET];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn || soft_reset_request) begin
            shaper_en <= 1'b0;
            coil_current_upper <= 2'h0;
            coil_current_lower <= 8'h00;
            upper_shadow <= 2'h0;
            pair_pending <= 1'b0;
            o_active_code <= coil_regs_pkg::CODE_STANDBY;
            diagnostic_request <= 1'b0;
            operating_options <= coil_regs_pkg::RESET_VALUE;
        end else begin
            if (wr_sys) begin
                shaper_en <= i_wr_data[coil_regs_pkg::BIT_SHAPER_EN];
            end
            if (wr_upper) begin
                coil_current_upper <= i_wr_data[1:0];
                upper_shadow <= i_wr_data[1:0];
            end
            if (wr_lower) begin
                coil_current_lower <= i_wr_data;
            end
            if (i_xfer_end) begin
                pair_pending <= 1'b0;
            end else if (wr_upper) begin
                pair_pending <= 1'b0;
            end else if (wr_lower) begin
                pair_pending <= coil_current_upper == upper_shadow && upper_armed;
            end
            if (commit) begin
                o_active_code <= next_code;
            end
            if (wr_flags) begin
                diagnostic_request <= i_wr_data[coil_regs_pkg::BIT_DIAGNOSTIC_REQUEST];
            end
            if (wr_opts) begin
                operating_options <= i_wr_data & coil_regs_pkg::OPTIONS_RW_MASK;
            end
        end
    end

    // upper written earlier in the same transfer arms the pair
    always_ff @(posedge i_clk) begin
        if (!i_rstn || soft_reset_request || i_xfer_end) begin
            upper_armed <= 1'b0;
        end else if (wr_upper) begin
            upper_armed <= 1'b1;
        end
    end

    // results valid once the settling delay has elapsed
    always_ff @(posedge i_clk) begin
        if (!i_rstn || soft_reset_request || !diagnostic_request || diagnostic_request_rise) begin
            diagnostic_request_valid <= 1'b0;
        end else if (diagnostic_request_tmr.expired) begin
            diagnostic_request_valid <= 1'b1;
        end
    end

    // thermal hysteresis, set above the high threshold, clear below the low
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            overtemp_flag <= 1'b0;
        end else if (hot_s) begin
            overtemp_flag <= 1'b1;
        end else if (cool_s) begin
            overtemp_flag <= 1'b0;
        end
    end

    // drive state machine
    always_comb begin
        next_state = state;
        unique case (state)
            ST_STANDBY: begin
                if (!zero_code) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (zero_code) begin
                    next_state = ST_STANDBY;
                end else if (overcur_s) begin
                    next_state = ST_LOCKED;
                end
            end
            ST_LOCKED: begin
                // a retry is only tried once the detector has gone quiet
                if (zero_code) begin
                    next_state = ST_STANDBY;
                end else if (retry_en && retry_tmr.expired && !overcur_s) begin
                    next_state = ST_RETRY;
                end
            end
            ST_RETRY: begin
                if (zero_code) begin
                    next_state = ST_STANDBY;
                end else if (overcur_s) begin
                    next_state = ST_LOCKED;
                end else begin
                    next_state = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn || soft_reset_request) begin
            state <= ST_STANDBY;
        end else begin
            state <= next_state;
        end
    end

    // lock flag held while locked or retrying, cleared on recovery
    always_ff @(posedge i_clk) begin
        if (!i_rstn || soft_reset_request) begin
            overcurrent_lock_flag <= 1'b0;
        end else begin
            overcurrent_lock_flag <= (next_state == ST_LOCKED) || (next_state == ST_RETRY);
        end
    end

    // outputs follow the state being entered, so standby and drive
    // change on the same edge
    wire logic operating = (next_state == ST_RUN || next_state == ST_RETRY) && !overtemp_flag;
    // fault bits gated by the request itself, so clearing it hides them at once
    wire logic diagnostic_request_ready = diagnostic_request && diagnostic_request_valid;
    wire logic [7:0] flags_view = {2'b00, diagnostic_request, overtemp_flag,
        diagnostic_request_ready && short_s, diagnostic_request_ready && open_s,
        1'b0, overcurrent_lock_flag};

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_drive_enable <= 1'b0;
            o_coil_drive_positive_oe <= 1'b0;
            o_coil_drive_negative_oe <= 1'b0;
            o_standby <= 1'b1;
        end else begin
            o_drive_enable <= operating;
            o_coil_drive_positive_oe <= operating;
            o_coil_drive_negative_oe <= operating;
            o_standby <= (next_state == ST_STANDBY);
        end
    end

    assign o_shaper_enable = shaper_en;
    // the request bit is already a flop, so soft reset clears it at once
    assign o_diagnostic_request_active = diagnostic_request;
    assign o_options = operating_options[6:1];

    wire logic [7:0] rd_mux =
        (i_rd_addr == coil_regs_pkg::ADDR_SYSTEM_CONTROL) ? {6'h00, shaper_en, soft_reset_bit} :
        (i_rd_addr == coil_regs_pkg::ADDR_CURRENT_UPPER) ? {6'h00, coil_current_upper} :
        (i_rd_addr == coil_regs_pkg::ADDR_CURRENT_LOWER) ? coil_current_lower :
        (i_rd_addr == coil_regs_pkg::ADDR_FLAGS) ? flags_view :
        (i_rd_addr == coil_regs_pkg::ADDR_OPTIONS) ? operating_options : 8'h00;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_rd_data <= 8'h00;
        end else begin
            o_rd_data <= rd_mux;
        end
    end
endmodule

// [src/coil_interval_timer.sv]
// restartable interval counter, pulses expired when the count runs out
// assumes start restarts the count and run low holds it idle
`timescale 1ns/1ps
module coil_interval_timer #(
    parameter int CYCLES = 200000
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    coil_timer_if.timer tmr
);
    logic [31:0] count;
    wire logic at_end = (count == 32'(CYCLES - 1));

    always_ff @(posedge i_clk) begin
        if (!i_rstn || tmr.start || !tmr.run) begin
            count <= 32'h0000_0000;
        end else if (at_end) begin
            count <= 32'h0000_0000;
        end else begin
            count <= count + 32'h0000_0001;
        end
    end

    assign tmr.expired = tmr.run && !tmr.start && at_end;
endmodule

// [src/coil_regs_pkg.sv]
// shared constants for the coil current control register bank
// assumes a 200 MHz core clock and a byte-wide register access port
package coil_regs_pkg;
    localparam int CLK_MHZ = 200;
    localparam logic [7:0] ADDR_SYSTEM_CONTROL = 8'h02;
    localparam logic [7:0] ADDR_CURRENT_UPPER = 8'h03;
    localparam logic [7:0] ADDR_CURRENT_LOWER = 8'h04;
    localparam logic [7:0] ADDR_FLAGS = 8'h05;
    localparam logic [7:0] ADDR_OPTIONS = 8'h06;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam int BIT_SOFT_RESET = 0;
    localparam int BIT_SHAPER_EN = 1;
    localparam int BIT_DIAGNOSTIC_REQUEST = 5;
    localparam int BIT_OVERTEMP = 4;
    localparam int BIT_SHORT = 3;
    localparam int BIT_OPEN = 2;
    localparam int BIT_LOCK = 0;
    localparam int BIT_RETRY = 7;
    localparam logic [7:0] OPTIONS_RW_MASK = 8'hDE;
    localparam logic [7:0] SYSCTL_RW_MASK = 8'h03;
    localparam logic [7:0] UPPER_RW_MASK = 8'h03;
    localparam int CODE_W = 10;
    localparam logic [9:0] CODE_STANDBY = 10'h000;
    localparam logic [9:0] CODE_FULL_SCALE = 10'h3FF;
    localparam int FULL_SCALE_UA = 100000;
    localparam int DIAGNOSTIC_REQUEST_DELAY_US = 1000;
    localparam int RETRY_PERIOD_US = 100000;
    localparam int DIAGNOSTIC_REQUEST_DELAY_CYCLES = DIAGNOSTIC_REQUEST_DELAY_US * CLK_MHZ;
    localparam int RETRY_PERIOD_CYCLES = RETRY_PERIOD_US * CLK_MHZ;
endpackage

// [src/coil_timer_if.sv]
// start/expire signals between the control bank and its interval timers
// assumes both ends share the core clock
`timescale 1ns/1ps
interface coil_timer_if;
    logic start;
    logic run;
    logic expired;
    modport owner (output start, output run, input expired);
    modport timer (input start, input run, output expired);
endinterface

// [testbench/coil_current_ctrl_regs_checker.sv]
// port assertions for the coil current control register bank
// assumes it is bound onto every instance of the bank
`timescale 1ns/1ps
module coil_current_ctrl_regs_checker #(
    parameter int DIAGNOSTIC_REQUEST_CYCLES = 20,
    parameter int RETRY_CYCLES = 50
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_wr_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_xfer_end,
    input wire logic [7:0] i_rd_addr,
    input wire logic [7:0] o_rd_data,
    input wire logic i_det_overtemp_hi,
    input wire logic i_det_overcurrent,
    input wire logic [9:0] o_active_code,
    input wire logic o_drive_enable,
    input wire logic o_coil_drive_positive_oe,
    input wire logic o_coil_drive_negative_oe,
    input wire logic o_standby,
    input wire logic o_diagnostic_request_active,
    input wire logic [5:0] o_options
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wire logic soft_wr;
    wire logic rd_flags;
    int diagnostic_request_cnt;
    assign soft_wr = i_wr_en && i_addr == coil_regs_pkg::ADDR_SYSTEM_CONTROL && i_wr_data[0];
    assign rd_flags = i_rd_addr == coil_regs_pkg::ADDR_FLAGS;
    // cycles since the diagnostic request went high, saturating
    always_ff @(posedge i_clk) begin
        if (!i_rstn || !o_diagnostic_request_active) begin
            diagnostic_request_cnt <= 0;
        end else if (diagnostic_request_cnt < DIAGNOSTIC_REQUEST_CYCLES) begin
            diagnostic_request_cnt <= diagnostic_request_cnt + 1;
        end
    end
    a_zero_code_standby: assert property (o_active_code == 10'h000 |=> o_standby)
        else $error("zero code without standby");
    a_standby_no_drive: assert property (o_standby |-> !o_drive_enable)
        else $error("drive enabled in standby");
    a_commit_on_end: assert property ($changed(o_active_code)
        |-> $past(i_xfer_end) || $past(soft_wr))
        else $error("setpoint changed outside transfer end");
    a_soft_reset_clears: assert property (soft_wr
        |=> o_active_code == 10'h000 && o_options == 6'h00 && !o_diagnostic_request_active)
        else $error("soft reset left state");
    a_diagnostic_request_idle_zero: assert property (rd_flags && !o_diagnostic_request_active
        && $past(o_diagnostic_request_active) == 1'b0 |=> o_rd_data[3:2] == 2'b00)
        else $error("fault flags set while idle");
    a_diagnostic_request_result_wait: assert property (rd_flags && o_diagnostic_request_active
        && diagnostic_request_cnt < DIAGNOSTIC_REQUEST_CYCLES - 3 |=> o_rd_data[3:2] == 2'b00)
        else $error("fault flags before settling");
    a_lock_output_hiz: assert property (i_det_overcurrent [*5]
        |=> !o_coil_drive_positive_oe && !o_coil_drive_negative_oe)
        else $error("outputs driven under overcurrent");
    a_overtemp_stop: assert property (i_det_overtemp_hi [*5] |=> !o_drive_enable)
        else $error("drive on while overheated");
    a_options_readback: assert property (i_rd_addr == coil_regs_pkg::ADDR_OPTIONS
        |=> o_rd_data[6:1] == $past(o_options) && !o_rd_data[0])
        else $error("options readback mismatch");
    c_commit: cover property ($changed(o_active_code));
    c_diagnostic_request_done: cover property (diagnostic_request_cnt == DIAGNOSTIC_REQUEST_CYCLES);
    c_lock: cover property ($fell(o_coil_drive_positive_oe));
endmodule
bind coil_current_ctrl_regs coil_current_ctrl_regs_checker #(.DIAGNOSTIC_REQUEST_CYCLES(DIAGNOSTIC_REQUEST_CYCLES),
    .RETRY_CYCLES(RETRY_CYCLES)) u_chk (.i_clk, .i_rstn, .i_wr_en, .i_addr, .i_wr_data,
    .i_xfer_end, .i_rd_addr, .o_rd_data, .i_det_overtemp_hi, .i_det_overcurrent,
    .o_active_code, .o_drive_enable, .o_coil_drive_positive_oe, .o_coil_drive_negative_oe,
    .o_standby, .o_diagnostic_request_active, .o_options);

// [testbench/coil_current_ctrl_regs_test.sv]
// self-checking bench for the coil current control register bank
// assumes the master model drives the write port and the bench the detectors
`timescale 1ns/1ps
module coil_current_ctrl_regs_test;
    localparam int DIAGNOSTIC_REQUEST = 20;
    localparam int RETRY = 50;
    typedef struct packed {logic [7:0] up; logic [7:0] lo; logic [9:0] code;} row_t;
    row_t rows [4] = '{'{8'h03, 8'hFF, 10'h3FF}, '{8'hFE, 8'h01, 10'h201},
        '{8'h00, 8'h00, 10'h000}, '{8'h01, 8'h80, 10'h180}};
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_wr_en, i_xfer_end;
    logic [7:0] i_addr, i_wr_data, o_rd_data, r;
    logic [7:0] i_rd_addr = 8'h00;
    logic i_det_short = 1'b0, i_det_open = 1'b0, i_det_overtemp_hi = 1'b0;
    logic i_det_overtemp_lo = 1'b0, i_det_overcurrent = 1'b0;
    logic [9:0] o_active_code;
    logic [5:0] o_options;
    logic o_drive_enable, o_coil_drive_positive_oe, o_coil_drive_negative_oe;
    logic o_standby, o_diagnostic_request_active, o_shaper_enable;
    int num_errors = 0;
    int checked = 0;
    coil_master_model u_m (.i_clk, .o_wr_en(i_wr_en), .o_addr(i_addr), .o_wr_data(i_wr_data),
        .o_xfer_end(i_xfer_end));
    coil_current_ctrl_regs #(.DIAGNOSTIC_REQUEST_CYCLES(DIAGNOSTIC_REQUEST), .RETRY_CYCLES(RETRY)) u_dut (.i_clk, .i_rstn,
        .i_wr_en, .i_addr, .i_wr_data, .i_xfer_end, .i_rd_addr, .o_rd_data, .i_det_short,
        .i_det_open, .i_det_overtemp_hi, .i_det_overtemp_lo, .i_det_overcurrent, .o_active_code,
        .o_drive_enable, .o_coil_drive_positive_oe, .o_coil_drive_negative_oe, .o_standby,
        .o_diagnostic_request_active, .o_shaper_enable, .o_options);
    initial begin
        forever #2.5 i_clk = ~i_clk;
    end
    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_out(input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: output %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_rd_addr <= a;
        repeat (2) @(posedge i_clk);
        #1 r = o_rd_data;
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // detector levels: short, open, overtemp high, overtemp low, overcurrent
    task automatic det(input logic [4:0] v);
        @(posedge i_clk);
        {i_det_short, i_det_open, i_det_overtemp_hi, i_det_overtemp_lo, i_det_overcurrent} <= v;
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge i_clk);
        num_errors++;
        results();
    end
    initial begin
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        for (int a = 2; a < 7; a++) begin
            rd(a[7:0]);
            check_reg(r, 8'h00);
        end
        check_out({9'h000, o_standby}, 10'h001);
        foreach (rows[i]) begin
            u_m.xfer(coil_regs_pkg::ADDR_CURRENT_UPPER, rows[i].up, rows[i].lo, 2);
            waitc(3);
            check_out(o_active_code, rows[i].code);
            check_out({9'h000, o_standby}, {9'h000, rows[i].code == 10'h000});
            rd(coil_regs_pkg::ADDR_CURRENT_UPPER);
            check_reg(r, {6'h00, rows[i].up[1:0]});
        end
        // lone bytes and an unmapped write never move the setpoint
        u_m.xfer(coil_regs_pkg::ADDR_CURRENT_UPPER, 8'h00, 8'h00, 1);
        u_m.xfer(coil_regs_pkg::ADDR_CURRENT_LOWER, 8'h11, 8'h00, 1);
        u_m.xfer(8'h20, 8'hFF, 8'h00, 1);
        waitc(3);
        check_out(o_active_code, 10'h180);
        u_m.xfer(coil_regs_pkg::ADDR_OPTIONS, 8'hFF, 8'h00, 1);
        rd(coil_regs_pkg::ADDR_OPTIONS);
        check_reg(r, 8'hDE);
        check_out({4'h0, o_options}, 10'h02F);
        u_m.xfer(coil_regs_pkg::ADDR_OPTIONS, 8'h00, 8'h00, 1);
        // diagnostic with both faults present, read-only bits written too
        det(5'b11000);
        u_m.xfer(coil_regs_pkg::ADDR_FLAGS, 8'h3D, 8'h00, 1);
        rd(coil_regs_pkg::ADDR_FLAGS);
        check_reg(r, 8'h20);
        check_out({9'h000, o_diagnostic_request_active}, 10'h001);
        waitc(DIAGNOSTIC_REQUEST + 5);
        rd(coil_regs_pkg::ADDR_FLAGS);
        check_reg(r, 8'h2C);
        det(5'b01000);
        waitc(5);
        rd(coil_regs_pkg::ADDR_FLAGS);
        check_reg(r, 8'h24);
        u_m.xfer(coil_regs_pkg::ADDR_FLAGS, 8'h00, 8'h00, 1);
        rd(coil_regs_pkg::ADDR_FLAGS);
        check_reg(r, 8'h00);
        det(5'b00100);
        waitc(6);
        rd(coil_regs_pkg::ADDR_FLAGS);
        check_reg(r, 8'h10);
        check_out({9'h000, o_drive_enable}, 10'h000);
        det(5'b00010);
        waitc(6);
        rd(coil_regs_pkg::ADDR_FLAGS);
        check_reg(r, 8'h00);
        check_out({9'h000, o_drive_enable}, 10'h001);
        // overcurrent without retry holds until a zero code
        det(5'b00001);
        waitc(6);
        det(5'b00000);
        rd(coil_regs_pkg::ADDR_FLAGS);
        check_reg(r, 8'h01);
        check_out({8'h00, o_coil_drive_positive_oe, o_coil_drive_negative_oe}, 10'h000);
        waitc(RETRY * 2);
        rd(coil_regs_pkg::ADDR_FLAGS);
        check_reg(r, 8'h01);
        u_m.xfer(coil_regs_pkg::ADDR_CURRENT_UPPER, 8'h00, 8'h00, 2);
        rd(coil_regs_pkg::ADDR_FLAGS);
        check_reg(r, 8'h00);
        // overcurrent with retry recovers on its own
        u_m.xfer(coil_regs_pkg::ADDR_OPTIONS, 8'h80, 8'h00, 1);
        u_m.xfer(coil_regs_pkg::ADDR_CURRENT_UPPER, 8'h03, 8'hFF, 2);
        det(5'b00001);
        waitc(6);
        det(5'b00000);
        rd(coil_regs_pkg::ADDR_FLAGS);
        check_reg(r, 8'h01);
        waitc(RETRY + 10);
        rd(coil_regs_pkg::ADDR_FLAGS);
        check_reg(r, 8'h00);
        check_out({9'h000, o_coil_drive_positive_oe}, 10'h001);
        u_m.xfer(coil_regs_pkg::ADDR_SYSTEM_CONTROL, 8'h02, 8'h00, 1);
        waitc(1);
        check_out({9'h000, o_shaper_enable}, 10'h001);
        u_m.xfer(coil_regs_pkg::ADDR_SYSTEM_CONTROL, 8'h03, 8'h00, 1);
        rd(coil_regs_pkg::ADDR_SYSTEM_CONTROL);
        check_reg(r, 8'h01);
        rd(coil_regs_pkg::ADDR_OPTIONS);
        check_reg(r, 8'h00);
        check_out(o_active_code, 10'h000);
        check_out({9'h000, o_standby}, 10'h001);
        check_out({9'h000, o_shaper_enable}, 10'h000);
        check_out({9'h000, o_diagnostic_request_active}, 10'h000);
        results();
    end
endmodule

// [testbench/coil_master_model.sv]
// byte-level model of the serial master feeding the register port
// drives the address of each byte itself, a then a+1 within a transfer
`timescale 1ns/1ps
module coil_master_model (
    input wire logic i_clk,
    output logic o_wr_en,
    output logic [7:0] o_addr,
    output logic [7:0] o_wr_data,
    output logic o_xfer_end
);
    initial begin
        o_wr_en = 1'b0;
        o_addr = 8'h00;
        o_wr_data = 8'h00;
        o_xfer_end = 1'b0;
    end
    // one transfer of one byte, or two when n is 2, from address a, then stop
    task automatic xfer(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1,
        input int n);
        @(posedge i_clk);
        o_wr_en <= 1'b1;
        o_addr <= a;
        o_wr_data <= d0;
        if (n == 2) begin
            @(posedge i_clk);
            o_addr <= a + 8'h01;
            o_wr_data <= d1;
        end
        @(posedge i_clk);
        o_wr_en <= 1'b0;
        o_wr_data <= ~o_wr_data;
        o_xfer_end <= 1'b1;
        @(posedge i_clk);
        o_xfer_end <= 1'b0;
    endtask
endmodule
